// File: src/lpfm_pkg.sv
// Constants, register map and mode codes for the layer-4 list match entry
package lpfm_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SRC = 8'h04;
    localparam logic [7:0] ADDR_DST = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_COUNT = 8'h10;

    // Control word field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PROTO_LSB = 1;
    localparam int CTRL_SMODE_LSB = 3;
    localparam int CTRL_DMODE_LSB = 5;
    localparam int CTRL_FLAG_LSB = 7;
    localparam int FLAG_CNT = 6;

    // Bound word field positions
    localparam int BOUND_LO_LSB = 0;
    localparam int BOUND_HI_LSB = 16;

    // Status word field positions
    localparam int STAT_HIT_BIT = 0;
    localparam int STAT_SEEN_BIT = 1;

    // Reset values: entry off, everything don't-care
    localparam logic [31:0] CTRL_RESET = 32'h0005_5500;
    localparam logic [31:0] BOUND_RESET = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

    // Port criterion modes
    typedef enum logic [1:0] {
        PMODE_ANY = 2'b00,
        PMODE_SPECIFIC = 2'b01,
        PMODE_RANGE = 2'b10
    } lpfm_port_mode_t;

    // Protocol selection of the entry
    typedef enum logic [1:0] {
        PROTO_ANY = 2'b00,
        PROTO_UDP = 2'b01,
        PROTO_TCP = 2'b10
    } lpfm_proto_t;

    // TCP flag criterion
    typedef enum logic [1:0] {
        FCRIT_CLEAR = 2'b00,
        FCRIT_SET = 2'b01,
        FCRIT_ANY = 2'b10
    } lpfm_flag_crit_t;

    // Flag bit order on the parser's flag bus
    localparam int FLAG_FIN = 0;
    localparam int FLAG_SYN = 1;
    localparam int FLAG_RST = 2;
    localparam int FLAG_PSH = 3;
    localparam int FLAG_ACK = 4;
    localparam int FLAG_URG = 5;

endpackage

// File: src/lpfm_port_check.sv
// One TCP/UDP port comparator: don't-care, exact value or inclusive range
`timescale 1ns/1ps
module lpfm_port_check #(
    parameter int PORT_W = 16
) (
    input wire logic [1:0] mode, // Criterion mode code
    input wire logic [PORT_W-1:0] port, // Port number from the frame
    input wire logic [PORT_W-1:0] bound_lo, // Exact value or lower bound
    input wire logic [PORT_W-1:0] bound_hi, // Upper bound for range mode
    output logic pass // Frame passes this criterion
);

    ////////////////////////////////////////////////////////////////////////////
    // Comparison; an unknown mode code rejects so a bad write cannot open the entry
    always_comb begin
        case (mode)
            lpfm_pkg::PMODE_ANY: begin
                pass = 1'b1;
            end
            lpfm_pkg::PMODE_SPECIFIC: begin
                pass = (port == bound_lo);
            end
            lpfm_pkg::PMODE_RANGE: begin
                pass = (port >= bound_lo) && (port <= bound_hi);
            end
            default: begin
                pass = 1'b0;
            end
        endcase
    end

endmodule

// File: src/lpfm_matcher.sv
// Layer-4 port and TCP flag match stage of one list match entry, Wishbone configured
// Function
// - Source criterion any: source port never causes a reject.
// - Source criterion specific: source port must equal the configured value.
// - Source criterion range: source port must lie within configured bounds.
// - Destination criterion any: destination port is ignored.
// - Destination criterion specific: destination port must equal the configured value.
// - Destination criterion range: destination port must lie within configured bounds.
// - FIN criterion: 0 bars set flag, 1 requires set, any ignores.
// - SYN criterion: 0 bars set flag, 1 requires set, any ignores.
// - RST criterion: 0 bars set flag, 1 requires set, any ignores.
// - PSH criterion: 0 bars set flag, 1 requires set, any ignores.
// - ACK criterion: 0 bars set flag, 1 requires set, any ignores.
// - URG criterion: 0 bars set flag, 1 requires set, any ignores.
// - Port criteria apply only for UDP or TCP selection, restricting protocol.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module lpfm_matcher #(
    parameter int PORT_W = 16,
    parameter int ADDR_W = 8
) (
    input wire logic clk, // 50 MHz clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [ADDR_W-1:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte enables
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic frame_valid, // Parsed header present this cycle
    input wire logic frame_is_tcp, // Frame carries TCP
    input wire logic frame_is_udp, // Frame carries UDP
    input wire logic [PORT_W-1:0] frame_src_port, // TCP/UDP source port
    input wire logic [PORT_W-1:0] frame_dst_port, // TCP/UDP destination port
    input wire logic [5:0] frame_tcp_flags, // FIN SYN RST PSH ACK URG, bit 0 first
    output logic match_valid, // Result strobe, one cycle
    output logic match_hit // Entry hit, valid with match_valid
);

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] src_bounds;
        logic [31:0] dst_bounds;
        logic ack;
        logic [31:0] rdata;
        logic match_valid;
        logic match_hit;
        logic last_hit;
        logic seen;
        logic [31:0] hit_count;
    } lpfm_state_t;

    lpfm_state_t state_reg;
    lpfm_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // Field decoders, shared by the match logic and the checks
    function automatic logic [1:0] field2(input logic [31:0] word, input int lsb);
        field2 = word[lsb +: 2];
    endfunction

    function automatic logic [PORT_W-1:0] bound(input logic [31:0] word, input int lsb);
        bound = word[lsb +: PORT_W];
    endfunction

    // Byte-lane merge of a write into an existing word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        merge = res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decoded configuration
    logic cfg_en;
    logic [1:0] proto;
    logic [1:0] src_mode;
    logic [1:0] dst_mode;
    logic [PORT_W-1:0] src_lo;
    logic [PORT_W-1:0] src_hi;
    logic [PORT_W-1:0] dst_lo;
    logic [PORT_W-1:0] dst_hi;

    assign cfg_en = state_reg.ctrl[lpfm_pkg::CTRL_EN_BIT];
    assign proto = field2(state_reg.ctrl, lpfm_pkg::CTRL_PROTO_LSB);
    assign src_mode = field2(state_reg.ctrl, lpfm_pkg::CTRL_SMODE_LSB);
    assign dst_mode = field2(state_reg.ctrl, lpfm_pkg::CTRL_DMODE_LSB);
    assign src_lo = bound(state_reg.src_bounds, lpfm_pkg::BOUND_LO_LSB);
    assign src_hi = bound(state_reg.src_bounds, lpfm_pkg::BOUND_HI_LSB);
    assign dst_lo = bound(state_reg.dst_bounds, lpfm_pkg::BOUND_LO_LSB);
    assign dst_hi = bound(state_reg.dst_bounds, lpfm_pkg::BOUND_HI_LSB);

    ////////////////////////////////////////////////////////////////////////////
    // Port comparators
    logic src_pass;
    logic dst_pass;

    lpfm_port_check #(.PORT_W(PORT_W)) u_src_check (
        .mode(src_mode),
        .port(frame_src_port),
        .bound_lo(src_lo),
        .bound_hi(src_hi),
        .pass(src_pass)
    );

    lpfm_port_check #(.PORT_W(PORT_W)) u_dst_check (
        .mode(dst_mode),
        .port(frame_dst_port),
        .bound_lo(dst_lo),
        .bound_hi(dst_hi),
        .pass(dst_pass)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-flag criteria; a spare code 3 acts as don't-care
    logic [lpfm_pkg::FLAG_CNT-1:0] flag_pass;
    logic [1:0] flag_crit [lpfm_pkg::FLAG_CNT];

    generate
        for (genvar i = 0; i < lpfm_pkg::FLAG_CNT; i++) begin : g_flag
            assign flag_crit[i] = field2(state_reg.ctrl, lpfm_pkg::CTRL_FLAG_LSB + 2 * i);
            assign flag_pass[i] = (flag_crit[i] == lpfm_pkg::FCRIT_CLEAR) ? !frame_tcp_flags[i] :
                                  (flag_crit[i] == lpfm_pkg::FCRIT_SET) ? frame_tcp_flags[i] : 1'b1;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Combined decision
    logic proto_ok;
    logic ports_ok;
    logic flags_ok;
    logic hit_now;

    // Port criteria only bind when a layer-4 protocol is selected
    assign proto_ok = (proto == lpfm_pkg::PROTO_UDP) ? frame_is_udp :
                      (proto == lpfm_pkg::PROTO_TCP) ? frame_is_tcp : 1'b1;
    assign ports_ok = (proto == lpfm_pkg::PROTO_ANY) || (src_pass && dst_pass);
    // Flags are looked at only for TCP entries on TCP frames
    assign flags_ok = !(proto == lpfm_pkg::PROTO_TCP && frame_is_tcp) || (&flag_pass);
    assign hit_now = cfg_en && proto_ok && ports_ok && flags_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Bus request decode
    logic bus_req;
    logic bus_wr;
    logic [ADDR_W-1:0] adr;

    // Ack is held off for one cycle after each answer so one request gives one ack
    assign bus_req = wb_cyc_i && wb_stb_i && !state_reg.ack;
    assign bus_wr = bus_req && wb_we_i;
    assign adr = wb_adr_i;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.ack = bus_req;
        state_next.match_valid = frame_valid;
        state_next.match_hit = frame_valid && hit_now;
        if (bus_wr) begin
            case (adr)
                ADDR_W'(lpfm_pkg::ADDR_CTRL): begin
                    state_next.ctrl = merge(state_reg.ctrl, wb_dat_i, wb_sel_i);
                end
                ADDR_W'(lpfm_pkg::ADDR_SRC): begin
                    state_next.src_bounds = merge(state_reg.src_bounds, wb_dat_i, wb_sel_i);
                end
                ADDR_W'(lpfm_pkg::ADDR_DST): begin
                    state_next.dst_bounds = merge(state_reg.dst_bounds, wb_dat_i, wb_sel_i);
                end
                ADDR_W'(lpfm_pkg::ADDR_COUNT): begin
                    state_next.hit_count = lpfm_pkg::COUNT_RESET;
                end
                default: begin
                end
            endcase
        end
        // A hit in the clearing cycle still counts
        if (frame_valid) begin
            state_next.last_hit = hit_now;
            state_next.seen = 1'b1;
            if (hit_now) begin
                state_next.hit_count = (bus_wr && adr == ADDR_W'(lpfm_pkg::ADDR_COUNT)) ?
                                       32'h0000_0001 : state_reg.hit_count + 32'h0000_0001;
            end
        end
        // Read data; unmapped addresses answer with zero
        state_next.rdata = 32'h0000_0000;
        if (bus_req && !wb_we_i) begin
            case (adr)
                ADDR_W'(lpfm_pkg::ADDR_CTRL): begin
                    state_next.rdata = state_reg.ctrl;
                end
                ADDR_W'(lpfm_pkg::ADDR_SRC): begin
                    state_next.rdata = state_reg.src_bounds;
                end
                ADDR_W'(lpfm_pkg::ADDR_DST): begin
                    state_next.rdata = state_reg.dst_bounds;
                end
                ADDR_W'(lpfm_pkg::ADDR_STATUS): begin
                    state_next.rdata[lpfm_pkg::STAT_HIT_BIT] = state_reg.last_hit;
                    state_next.rdata[lpfm_pkg::STAT_SEEN_BIT] = state_reg.seen;
                end
                ADDR_W'(lpfm_pkg::ADDR_COUNT): begin
                    state_next.rdata = state_reg.hit_count;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg.ctrl <= lpfm_pkg::CTRL_RESET;
            state_reg.src_bounds <= lpfm_pkg::BOUND_RESET;
            state_reg.dst_bounds <= lpfm_pkg::BOUND_RESET;
            state_reg.ack <= 1'b0;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.match_valid <= 1'b0;
            state_reg.match_hit <= 1'b0;
            state_reg.last_hit <= 1'b0;
            state_reg.seen <= 1'b0;
            state_reg.hit_count <= lpfm_pkg::COUNT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.rdata;
    assign match_valid = state_reg.match_valid;
    assign match_hit = state_reg.match_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the decision, one cycle after the header is presented, and on the bus ack
    src_any_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
        (frame_valid && cfg_en && proto == lpfm_pkg::PROTO_UDP && frame_is_udp &&
         src_mode == lpfm_pkg::PMODE_ANY && dst_mode == lpfm_pkg::PMODE_ANY)
        |=> (match_valid && match_hit))
        else $error("source any rejected a frame");

    src_spec_miss_a: assert property (@(posedge clk) disable iff (!reset_n)
        (frame_valid && proto != lpfm_pkg::PROTO_ANY && src_mode == lpfm_pkg::PMODE_SPECIFIC &&
         frame_src_port != src_lo)
        |=> (match_valid && !match_hit))
        else $error("source specific hit on wrong port");

    src_range_out_a: assert property (@(posedge clk) disable iff (!reset_n)
        (frame_valid && proto != lpfm_pkg::PROTO_ANY && src_mode == lpfm_pkg::PMODE_RANGE &&
         (frame_src_port < src_lo || frame_src_port > src_hi))
        |=> !match_hit)
        else $error("source range hit outside bounds");

    dst_any_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
        (frame_valid && cfg_en && proto == lpfm_pkg::PROTO_TCP && frame_is_tcp &&
         src_mode == lpfm_pkg::PMODE_ANY && dst_mode == lpfm_pkg::PMODE_ANY &&
         state_reg.ctrl[lpfm_pkg::CTRL_FLAG_LSB +: 12] == lpfm_pkg::CTRL_RESET[lpfm_pkg::CTRL_FLAG_LSB +: 12])
        |=> match_hit)
        else $error("destination any rejected a frame");

    dst_spec_miss_a: assert property (@(posedge clk) disable iff (!reset_n)
        (frame_valid && proto != lpfm_pkg::PROTO_ANY && dst_mode == lpfm_pkg::PMODE_SPECIFIC &&
         frame_dst_port != dst_lo)
        |=> (match_valid && !match_hit))
        else $error("destination specific hit on wrong port");

    dst_range_out_a: assert property (@(posedge clk) disable iff (!reset_n)
        (frame_valid && proto != lpfm_pkg::PROTO_ANY && dst_mode == lpfm_pkg::PMODE_RANGE &&
         (frame_dst_port < dst_lo || frame_dst_port > dst_hi))
        |=> !match_hit)
        else $error("destination range hit outside bounds");

    generate
        for (genvar k = 0; k < lpfm_pkg::FLAG_CNT; k++) begin : g_flag_chk
            flag_crit_a: assert property (@(posedge clk) disable iff (!reset_n)
                (frame_valid && proto == lpfm_pkg::PROTO_TCP && frame_is_tcp &&
                 ((flag_crit[k] == lpfm_pkg::FCRIT_CLEAR && frame_tcp_flags[k]) ||
                  (flag_crit[k] == lpfm_pkg::FCRIT_SET && !frame_tcp_flags[k])))
                |=> !match_hit)
                else $error("flag criterion ignored");
        end
    endgenerate

    proto_restrict_a: assert property (@(posedge clk) disable iff (!reset_n)
        (frame_valid && ((proto == lpfm_pkg::PROTO_UDP && !frame_is_udp) ||
                         (proto == lpfm_pkg::PROTO_TCP && !frame_is_tcp)))
        |=> !match_hit)
        else $error("hit on frame of wrong protocol");

    range_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
        (frame_valid && cfg_en && proto == lpfm_pkg::PROTO_UDP && frame_is_udp &&
         src_mode == lpfm_pkg::PMODE_RANGE && src_lo <= src_hi &&
         (frame_src_port == src_lo || frame_src_port == src_hi) && dst_mode == lpfm_pkg::PMODE_ANY)
        |=> match_hit)
        else $error("range bound not inclusive");

    hit_needs_en_a: assert property (@(posedge clk) disable iff (!reset_n)
        match_hit |-> ($past(cfg_en) && match_valid))
        else $error("hit without enabled entry");

    bus_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle answer");

endmodule

// File: test/lpfm_parser_model.sv
// Behavioural frame parser that feeds decoded TCP/UDP headers to the matcher
`timescale 1ns/1ps
module lpfm_parser_model (
    input wire logic clk, // Shared clock
    input wire logic send, // Bench asks for one header this cycle
    input wire logic tcp, // Header is TCP
    input wire logic udp, // Header is UDP
    input wire logic [15:0] sp, // Source port to present
    input wire logic [15:0] dp, // Destination port to present
    input wire logic [5:0] fl, // TCP flags to present
    output logic frame_valid, // Header strobe
    output logic frame_is_tcp, // TCP marker
    output logic frame_is_udp, // UDP marker
    output logic [15:0] frame_src_port, // Source port
    output logic [15:0] frame_dst_port, // Destination port
    output logic [5:0] frame_tcp_flags // Flags
);
    ////////////////////////////////////////////////////////////////
    // Known idle state before the first edge
    initial begin
        frame_valid = 1'b0;
        {frame_is_tcp, frame_is_udp, frame_src_port, frame_dst_port, frame_tcp_flags} = '0;
    end

    // One-cycle header; between headers the fields toggle so stale data can never pass as valid
    always @(posedge clk) begin
        frame_valid <= send;
        if (send) begin
            {frame_is_tcp, frame_is_udp} <= {tcp, udp};
            {frame_src_port, frame_dst_port, frame_tcp_flags} <= {sp, dp, fl};
        end else begin
            {frame_is_tcp, frame_is_udp} <= ~{frame_is_tcp, frame_is_udp};
            {frame_src_port, frame_dst_port, frame_tcp_flags} <= ~{frame_src_port, frame_dst_port, frame_tcp_flags};
        end
    end
endmodule

// File: test/tb.sv
// Self-checking testbench for the layer-4 list match entry
`timescale 1ns/1ps
module tb;
    logic clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, match_valid, match_hit;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, ctrl_m, src_m, dst_m, rd, exp_cnt;
    logic send, p_tcp, p_udp, f_valid, f_tcp, f_udp, last_hit, seen;
    logic [15:0] p_sp, p_dp, f_sp, f_dp;
    logic [5:0] p_fl, f_fl;
    int fails, checks_done;
    logic [15:0] pl [4] = '{16'h0063, 16'h0064, 16'h00c8, 16'h00c9};

    ////////////////////////////////////////////////////////////////
    lpfm_matcher DUT (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_valid(f_valid), .frame_is_tcp(f_tcp),
        .frame_is_udp(f_udp), .frame_src_port(f_sp), .frame_dst_port(f_dp),
        .frame_tcp_flags(f_fl), .match_valid(match_valid), .match_hit(match_hit));
    lpfm_parser_model parser (.clk(clk), .send(send), .tcp(p_tcp), .udp(p_udp), .sp(p_sp),
        .dp(p_dp), .fl(p_fl), .frame_valid(f_valid), .frame_is_tcp(f_tcp), .frame_is_udp(f_udp),
        .frame_src_port(f_sp), .frame_dst_port(f_dp), .frame_tcp_flags(f_fl));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    // Checking and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Generous bound: the whole run needs only about twelve hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////
    // Expected result worked out from the entry settings alone
    function automatic logic port_ok(input logic [1:0] m, input logic [15:0] p, input logic [31:0] b);
        case (m)
            lpfm_pkg::PMODE_ANY: return 1'b1;
            lpfm_pkg::PMODE_SPECIFIC: return p == b[15:0];
            lpfm_pkg::PMODE_RANGE: return p >= b[15:0] && p <= b[31:16];
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic exp_hit(input logic t, input logic u, input logic [15:0] sp,
                                     input logic [15:0] dp, input logic [5:0] fl);
        logic ok;
        logic [1:0] c;
        ok = ctrl_m[0];
        if (ctrl_m[2:1] != lpfm_pkg::PROTO_ANY) begin
            ok = ok & port_ok(ctrl_m[4:3], sp, src_m) & port_ok(ctrl_m[6:5], dp, dst_m);
            ok = ok & ((ctrl_m[2:1] == lpfm_pkg::PROTO_UDP) ? u : t);
        end
        if (ctrl_m[2:1] == lpfm_pkg::PROTO_TCP) begin
            for (int i = 0; i < 6; i++) begin
                c = ctrl_m[7 + 2 * i +: 2];
                if ((c == lpfm_pkg::FCRIT_CLEAR && fl[i]) || (c == lpfm_pkg::FCRIT_SET && !fl[i])) ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic [31:0] mk_ctrl(input logic en, input logic [1:0] pr, input logic [1:0] sm,
                                            input logic [1:0] dm, input logic [11:0] fc);
        return {13'h0, fc, dm, sm, pr, en};
    endfunction

    ////////////////////////////////////////////////////////////////
    // Wishbone classic single cycle; ack and read data are taken at the edge that sees ack, request drops there
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, 4'hf, wd};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask

    task automatic cfg(input logic [31:0] c, input logic [31:0] s, input logic [31:0] d);
        {ctrl_m, src_m, dst_m} = {c, s, d};
        wb_xfer(1'b1, lpfm_pkg::ADDR_CTRL, c);
        wb_xfer(1'b1, lpfm_pkg::ADDR_SRC, s);
        wb_xfer(1'b1, lpfm_pkg::ADDR_DST, d);
        wb_xfer(1'b0, lpfm_pkg::ADDR_CTRL, 32'h0);
        chk(rd, c);
    endtask

    // One header through the parser; the result strobe must follow the take by exactly one cycle
    task automatic run_frame(input logic t, input logic u, input logic [15:0] sp, input logic [15:0] dp,
                             input logic [5:0] fl);
        logic e;
        e = exp_hit(t, u, sp, dp, fl);
        @(posedge clk);
        {send, p_tcp, p_udp, p_sp, p_dp, p_fl} <= {1'b1, t, u, sp, dp, fl};
        @(posedge clk);
        send <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk({31'h0, match_valid}, 32'h1);
        chk({31'h0, match_hit}, {31'h0, e});
        exp_cnt = exp_cnt + {31'h0, e};
        {last_hit, seen} = {e, 1'b1};
    endtask

    function automatic logic [15:0] pick(input logic [31:0] b);
        case ($urandom % 5)
            0: return b[15:0];
            1: return b[31:16];
            2: return 16'(b[15:0] - 16'h1);
            3: return 16'(b[31:16] + 16'h1);
            default: return 16'($urandom);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [15:0] a, b;
        logic [1:0] pr;
        logic [11:0] fc;
        logic [31:0] rv [5];
        logic [7:0] ra [5];
        {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {send, p_tcp, p_udp, p_sp, p_dp, p_fl, exp_cnt, last_hit, seen} = '0;
        {fails, checks_done} = '0;
        void'($urandom(39190));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values, then an unmapped place that reads zero and ignores writes
        rv = '{lpfm_pkg::CTRL_RESET, lpfm_pkg::BOUND_RESET, lpfm_pkg::BOUND_RESET, 32'h0, lpfm_pkg::COUNT_RESET};
        ra = '{lpfm_pkg::ADDR_CTRL, lpfm_pkg::ADDR_SRC, lpfm_pkg::ADDR_DST, lpfm_pkg::ADDR_STATUS, lpfm_pkg::ADDR_COUNT};
        foreach (ra[k]) begin
            wb_xfer(1'b0, ra[k], 32'h0);
            chk(rd, rv[k]);
        end
        wb_xfer(1'b1, 8'h14, 32'hdead_beef);
        wb_xfer(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        // Each flag under each criterion, with the flag both set and clear
        for (int i = 0; i < 6; i++) begin
            for (int c = 0; c < 3; c++) begin
                fc = 12'haaa;
                fc[2 * i +: 2] = 2'(c);
                cfg(mk_ctrl(1'b1, lpfm_pkg::PROTO_TCP, 2'b00, 2'b00, fc), 32'h0, 32'h0);
                run_frame(1'b1, 1'b0, 16'h1, 16'h2, 6'h3f);
                run_frame(1'b1, 1'b0, 16'h1, 16'h2, 6'h00);
            end
        end
        // Range edges and extreme exact values on each side, the other side don't-care
        for (int s = 0; s < 2; s++) begin
            cfg(mk_ctrl(1'b1, lpfm_pkg::PROTO_UDP, s ? 2'b00 : 2'b10, s ? 2'b10 : 2'b00, 12'haaa),
                32'h00c8_0064, 32'h00c8_0064);
            foreach (pl[k]) run_frame(1'b0, 1'b1, pl[k], pl[k], 6'h0);
            for (int v = 0; v < 2; v++) begin
                a = v ? 16'hffff : 16'h0000;
                cfg(mk_ctrl(1'b1, lpfm_pkg::PROTO_UDP, s ? 2'b00 : 2'b01, s ? 2'b01 : 2'b00, 12'haaa),
                    {16'h0, a}, {16'h0, a});
                run_frame(1'b0, 1'b1, a, a, 6'h0);
                run_frame(1'b0, 1'b1, a ^ 16'h1, a ^ 16'h1, 6'h0);
            end
        end
        // Protocol selection and the enable bit
        cfg(mk_ctrl(1'b1, lpfm_pkg::PROTO_TCP, 2'b01, 2'b01, 12'haaa), 32'h50, 32'h50);
        run_frame(1'b0, 1'b1, 16'h50, 16'h50, 6'h0);
        run_frame(1'b1, 1'b0, 16'h50, 16'h50, 6'h0);
        cfg(mk_ctrl(1'b1, lpfm_pkg::PROTO_ANY, 2'b01, 2'b01, 12'haaa), 32'h50, 32'h50);
        run_frame(1'b0, 1'b0, 16'h7, 16'h9, 6'h0);
        cfg(mk_ctrl(1'b0, lpfm_pkg::PROTO_ANY, 2'b00, 2'b00, 12'haaa), 32'h0, 32'h0);
        run_frame(1'b1, 1'b0, 16'h7, 16'h9, 6'h0);
        // Random entries, with frames aimed at the bounds; software keeps low not above high
        for (int r = 0; r < 20; r++) begin
            a = 16'($urandom);
            b = 16'($urandom);
            if (a > b) {a, b} = {b, a};
            pr = 2'($urandom % 3);
            for (int i = 0; i < 6; i++) fc[2 * i +: 2] = 2'($urandom % 3);
            if (pr != lpfm_pkg::PROTO_TCP) fc = 12'haaa;
            cfg(mk_ctrl(($urandom % 8) != 0, pr, 2'($urandom % 3), 2'($urandom % 3), fc), {b, a}, {b, a});
            repeat (6) begin
                pr = 2'($urandom % 3);
                run_frame(pr == 2'd0, pr == 2'd1, pick(src_m), pick(dst_m), 6'($urandom));
            end
        end
        // Hit counter and status, then clear by write
        wb_xfer(1'b0, lpfm_pkg::ADDR_COUNT, 32'h0);
        chk(rd, exp_cnt);
        wb_xfer(1'b0, lpfm_pkg::ADDR_STATUS, 32'h0);
        chk(rd, {30'h0, seen, last_hit});
        wb_xfer(1'b1, lpfm_pkg::ADDR_COUNT, 32'h1234);
        wb_xfer(1'b0, lpfm_pkg::ADDR_COUNT, 32'h0);
        chk(rd, 32'h0);
        // Mid-run reset must bring the entry back to its off state
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        wb_xfer(1'b0, lpfm_pkg::ADDR_CTRL, 32'h0);
        chk(rd, lpfm_pkg::CTRL_RESET);
        wb_xfer(1'b0, lpfm_pkg::ADDR_COUNT, 32'h0);
        chk(rd, lpfm_pkg::COUNT_RESET);
        summarize();
    end
endmodule
